// file: sbi_pkg.sv
// Shared constants for the snooping bus interface block.
// Assumes a single 50 MHz processor clock and a 32-bit physical address space.
package sbi_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int OFS_W = 4;
  localparam int SETS = 16;
  localparam int SET_W = 4;
  localparam int WAYS = 4;
  localparam int TAG_W = ADDR_W - OFS_W - SET_W;
  localparam int WAIT_W = 4;
  localparam logic [WAIT_W-1:0] WAIT_DEFAULT = 4'h2;
  typedef enum logic [1:0] {
    SBI_INVALID = 2'b00,
    SBI_VALID = 2'b01,
    SBI_DIRTY = 2'b10
  } sbi_line_t;
  typedef enum logic [1:0] {
    SBI_IDLE = 2'b00,
    SBI_ADDR = 2'b01,
    SBI_WAIT = 2'b10,
    SBI_DONE = 2'b11
  } sbi_state_t;
endpackage

// file: sbi_core.sv
// Bus controller plus snoop tag array of the snooping bus interface.
// Assumes bus pins arrive asynchronously and pass a two-stage synchroniser here.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Separate address/data, all on rising clk.
// - Bus acts only on qualified edges.
// - Bus runs independent of internal cache use.
// - Wait count configurable per memory speed.
// - Snoopable foreign cycles invalidate matching lines.
// - Snoop beats execution unit for caches.
// - Four-way, 16-byte lines, three line states.
module sbi_core (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Bus pins.
  input wire logic bus_edge_qualifier_n_i,
  input wire logic bus_ready_n_i,
  input wire logic [sbi_pkg::DATA_W-1:0] bus_data_i,
  input wire logic ext_start_n_i,
  input wire logic ext_snoop_i,
  input wire logic [sbi_pkg::ADDR_W-1:0] ext_addr_i,
  output logic [sbi_pkg::ADDR_W-1:0] bus_addr_o,
  output logic bus_start_n_o,
  output logic bus_active_o,
  // Configuration strap-like input from core logic.
  input wire logic [sbi_pkg::WAIT_W-1:0] wait_cfg_i,
  // Core request port (same clock).
  input wire logic req_valid_i,
  input wire logic [sbi_pkg::ADDR_W-1:0] req_addr_i,
  output logic req_ready_o,
  output logic rsp_valid_o,
  output logic [sbi_pkg::DATA_W-1:0] rsp_data_o,
  // Execution unit cache access (same clock).
  input wire logic eu_req_i,
  input wire logic [sbi_pkg::ADDR_W-1:0] eu_addr_i,
  input wire logic eu_fill_i,
  input wire logic eu_dirty_i,
  output logic eu_grant_o,
  output logic eu_hit_o,
  // Snoop status.
  output logic snoop_inval_o
);
  import sbi_pkg::*;

  // Two-flop synchronisers on every asynchronous pin; only stage two is read.
  logic qn_s1_r, qn_s2_r, rdy_s1_r, rdy_s2_r, st_s1_r, st_s2_r, sn_s1_r, sn_s2_r;
  logic [DATA_W-1:0] d_s1_r, d_s2_r;
  logic [ADDR_W-1:0] xa_s1_r, xa_s2_r;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {qn_s1_r, qn_s2_r, rdy_s1_r, rdy_s2_r} <= 4'hF;
      {st_s1_r, st_s2_r, sn_s1_r, sn_s2_r} <= 4'hC;
      d_s1_r <= '0;
      d_s2_r <= '0;
      xa_s1_r <= '0;
      xa_s2_r <= '0;
    end else begin
      qn_s1_r <= bus_edge_qualifier_n_i;
      qn_s2_r <= qn_s1_r;
      rdy_s1_r <= bus_ready_n_i;
      rdy_s2_r <= rdy_s1_r;
      st_s1_r <= ext_start_n_i;
      st_s2_r <= st_s1_r;
      sn_s1_r <= ext_snoop_i;
      sn_s2_r <= sn_s1_r;
      d_s1_r <= bus_data_i;
      d_s2_r <= d_s1_r;
      xa_s1_r <= ext_addr_i;
      xa_s2_r <= xa_s1_r;
    end
  end

  // A qualified edge is one where the active-low qualifier is asserted.
  logic bus_en;
  assign bus_en = !qn_s2_r;

  // Bus state machine; it stands still on unqualified edges.
  sbi_state_t state_r, state_nxt;
  logic [WAIT_W-1:0] wait_r;
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      SBI_IDLE: if (req_valid_i) state_nxt = SBI_ADDR;
      SBI_ADDR: state_nxt = SBI_WAIT;
      SBI_WAIT: if (wait_r == '0 && !rdy_s2_r) state_nxt = SBI_DONE;
      SBI_DONE: state_nxt = SBI_IDLE;
      default: state_nxt = SBI_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= SBI_IDLE;
    end else if (bus_en) begin
      state_r <= state_nxt;
    end
  end

  // Wait counter loads the configured access length at address phase.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_r <= WAIT_DEFAULT;
    end else if (bus_en) begin
      if (state_r == SBI_ADDR) begin
        wait_r <= wait_cfg_i;
      end else if (state_r == SBI_WAIT && wait_r != '0) begin
        wait_r <= wait_r - 1'b1;
      end
    end
  end

  // Address and strobe outputs are registered and only move on qualified edges.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_addr_o <= '0;
      bus_start_n_o <= 1'b1;
      bus_active_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_data_o <= '0;
    end else begin
      rsp_valid_o <= 1'b0;
      if (bus_en) begin
        bus_start_n_o <= !(state_r == SBI_IDLE && req_valid_i);
        if (state_r == SBI_IDLE && req_valid_i) begin
          bus_addr_o <= req_addr_i;
        end
        bus_active_o <= (state_nxt != SBI_IDLE);
        if (state_r == SBI_WAIT && state_nxt == SBI_DONE) begin
          rsp_data_o <= d_s2_r;
          rsp_valid_o <= 1'b1;
        end
      end
    end
  end

  // Request taken only in idle on a qualified edge.
  assign req_ready_o = bus_en && (state_r == SBI_IDLE);

  // Round-robin fill pointer; the tag and state arrays live per way below.
  logic [WAYS-1:0] victim_r;

  // Snoop request on every qualified edge while a foreign snoopable cycle holds its start strobe low.
  logic snoop_req;
  assign snoop_req = bus_en && !st_s2_r && sn_s2_r;
  // The snooper wins the tag port; the execution unit simply retries next cycle.
  assign eu_grant_o = eu_req_i && !snoop_req;

  logic [SET_W-1:0] sn_set, eu_set;
  logic [TAG_W-1:0] sn_tag, eu_tag;
  assign sn_set = xa_s2_r[OFS_W +: SET_W];
  assign sn_tag = xa_s2_r[ADDR_W-1 -: TAG_W];
  assign eu_set = eu_addr_i[OFS_W +: SET_W];
  assign eu_tag = eu_addr_i[ADDR_W-1 -: TAG_W];

  logic [WAYS-1:0] sn_hit, eu_hit;
  genvar w;
  generate
    for (w = 0; w < WAYS; w++) begin : g_way
      // Each way owns its arrays, so every array has exactly one writing process.
      logic [TAG_W-1:0] tag_r [SETS];
      sbi_line_t line_r [SETS];
      assign sn_hit[w] = (line_r[sn_set] != SBI_INVALID) && (tag_r[sn_set] == sn_tag);
      assign eu_hit[w] = (line_r[eu_set] != SBI_INVALID) && (tag_r[eu_set] == eu_tag);
      // Per-way line update: snoop invalidate first, else an execution fill.
      always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
          for (int s = 0; s < SETS; s++) begin
            line_r[s] <= SBI_INVALID;
            tag_r[s] <= '0;
          end
        end else if (snoop_req) begin
          if (sn_hit[w]) line_r[sn_set] <= SBI_INVALID;
        end else if (eu_grant_o && eu_fill_i && victim_r[w]) begin
          tag_r[eu_set] <= eu_tag;
          line_r[eu_set] <= eu_dirty_i ? SBI_DIRTY : SBI_VALID;
        end
      end
    end
  endgenerate

  // Round-robin victim pointer, advanced on each fill.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      victim_r <= 4'h1;
    end else if (!snoop_req && eu_grant_o && eu_fill_i) begin
      victim_r <= {victim_r[WAYS-2:0], victim_r[WAYS-1]};
    end
  end

  assign eu_hit_o = eu_grant_o && (|eu_hit);

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      snoop_inval_o <= 1'b0;
    end else begin
      snoop_inval_o <= snoop_req && (|sn_hit);
    end
  end

  // Checks.
  a_snoop_priority: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    snoop_req |-> !eu_grant_o) else $error("execution unit granted during snoop");
  a_frozen_state: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !bus_en |=> $stable(state_r)) else $error("bus state moved on unqualified edge");
  a_frozen_addr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !bus_en |=> $stable(bus_addr_o) && $stable(bus_start_n_o)) else $error("bus pins moved");
  a_snoop_inval: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (snoop_req && |sn_hit) |=> snoop_inval_o) else $error("snoop hit not flagged");
  a_no_snoop: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !snoop_req |=> !snoop_inval_o) else $error("invalidate without snoopable cycle");
  a_line_gone: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (snoop_req && sn_hit[0]) |=> g_way[0].line_r[$past(sn_set)] == SBI_INVALID)
    else $error("snooped line still valid");
  a_wait_load: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bus_en && state_r == SBI_ADDR) |=> wait_r == $past(wait_cfg_i))
    else $error("wait count not loaded");
  a_start_idle: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (bus_en && state_r == SBI_IDLE && req_valid_i) |=> !bus_start_n_o && state_r == SBI_ADDR)
    else $error("start strobe missing");
  a_eu_free: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (eu_req_i && !snoop_req && state_r != SBI_IDLE) |-> eu_grant_o)
    else $error("bus cycle stalled execution unit");
endmodule
`default_nettype wire

// file: sbi_partner.sv
// Far-side model: external memory answering own cycles, plus a second bus master.
// Assumes the bench calls its task and the block's pins settle by the falling edge.
`timescale 1ns/100ps
`default_nettype none
module sbi_partner #(parameter int DELAY = 3) (
  // Clock.
  input wire logic clk_i,
  // Own-cycle pins from the block.
  input wire logic [31:0] bus_addr_i,
  input wire logic bus_active_i,
  // Pins driven back to the block.
  output logic bus_ready_n_o,
  output logic [31:0] bus_data_o,
  output logic ext_start_n_o,
  output logic ext_snoop_o,
  output logic [31:0] ext_addr_o
);
  int cnt_r = 0;
  initial begin
    bus_ready_n_o = 1'b1;
    bus_data_o = '0;
    ext_start_n_o = 1'b1;
    ext_snoop_o = 1'b0;
    ext_addr_o = '0;
  end
  // Memory acks after DELAY edges; a released data bus flips each cycle so stale data shows.
  always @(negedge clk_i) begin
    cnt_r <= bus_active_i ? cnt_r + 1 : 0;
    bus_ready_n_o <= !(bus_active_i && cnt_r >= DELAY);
    bus_data_o <= (bus_active_i && cnt_r >= DELAY) ?
      {bus_addr_i[15:0], ~bus_addr_i[15:0]} : ~bus_data_o;
  end
  // Foreign cycle, held long enough for a quarter-rate qualified edge to see it.
  task automatic foreign(input logic [31:0] a, input logic snp);
    @(negedge clk_i);
    ext_addr_o = a;
    ext_snoop_o = snp;
    ext_start_n_o = 1'b0;
    repeat (8) @(negedge clk_i);
    ext_start_n_o = 1'b1;
    ext_addr_o = ~a;
  endtask
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the snooping bus interface core.
// Assumes the far-side model in its own file; inputs change on the falling edge.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import sbi_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic bus_edge_qualifier_n_i = 1'b0;
  logic bus_ready_n_i, ext_start_n_i, ext_snoop_i, bus_start_n_o, bus_active_o;
  logic [DATA_W-1:0] bus_data_i, rsp_data_o;
  logic [ADDR_W-1:0] ext_addr_i, bus_addr_o, req_addr_i = '0, eu_addr_i = '0;
  logic [WAIT_W-1:0] wait_cfg_i = WAIT_DEFAULT;
  logic req_valid_i = 1'b0, eu_req_i = 1'b0, eu_fill_i = 1'b0, eu_dirty_i = 1'b0;
  logic req_ready_o, rsp_valid_o, eu_grant_o, eu_hit_o, snoop_inval_o;
  int miscompares = 0;
  int comparisons = 0;
  int qdiv = 1;
  int qcnt = 0;
  sbi_core dut_u (.clk_i, .rst_b_i, .bus_edge_qualifier_n_i, .bus_ready_n_i, .bus_data_i,
    .ext_start_n_i, .ext_snoop_i, .ext_addr_i, .bus_addr_o, .bus_start_n_o, .bus_active_o,
    .wait_cfg_i, .req_valid_i, .req_addr_i, .req_ready_o, .rsp_valid_o, .rsp_data_o,
    .eu_req_i, .eu_addr_i, .eu_fill_i, .eu_dirty_i, .eu_grant_o, .eu_hit_o, .snoop_inval_o);
  sbi_partner part_u (.clk_i(clk_i), .bus_addr_i(bus_addr_o), .bus_active_i(bus_active_o),
    .bus_ready_n_o(bus_ready_n_i), .bus_data_o(bus_data_i), .ext_start_n_o(ext_start_n_i),
    .ext_snoop_o(ext_snoop_i), .ext_addr_o(ext_addr_i));
  // 50 MHz clock.
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  // Qualifier low one edge in qdiv; qdiv of zero holds the bus frozen.
  always @(negedge clk_i) begin
    qcnt <= qcnt + 1;
    bus_edge_qualifier_n_i <= (qdiv == 0) || (qcnt % qdiv != 0);
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One read; ready is stable from the falling edge to the taking edge.
  // The answer may not come sooner than min_cyc clocks after the request is taken.
  task automatic rd(input logic [31:0] a, input int min_cyc);
    int n;
    n = 0;
    @(negedge clk_i);
    req_addr_i = a;
    req_valid_i = 1'b1;
    while (req_ready_o !== 1'b1 && n < 40) begin
      @(negedge clk_i);
      n++;
    end
    chk("req_ready_o", 1, req_ready_o);
    @(negedge clk_i);
    req_valid_i = 1'b0;
    chk("bus_addr_o", a, bus_addr_o);
    chk("bus_start_n_o", 0, bus_start_n_o);
    chk("bus_active_o", 1, bus_active_o);
    n = 0;
    while (rsp_valid_o !== 1'b1 && n < 300) begin
      @(negedge clk_i);
      n++;
    end
    chk("rsp_valid_o", 1, rsp_valid_o);
    chk("rsp_data_o", {a[15:0], ~a[15:0]}, rsp_data_o);
    chk("rsp_wait_cycles", 1, n >= min_cyc);
  endtask
  // Fill a line, then a foreign cycle to it with different low address bits.
  task automatic sn(input logic [31:0] a, input logic snp);
    logic inv;
    logic drop;
    inv = 1'b0;
    drop = 1'b0;
    @(negedge clk_i);
    eu_addr_i = a;
    eu_dirty_i = snp;
    eu_req_i = 1'b1;
    eu_fill_i = 1'b1;
    @(negedge clk_i);
    eu_fill_i = 1'b0;
    @(negedge clk_i);
    chk("eu_hit_o", 1, eu_hit_o);
    fork
      part_u.foreign(a ^ 32'hF, snp);
      repeat (12) begin
        @(negedge clk_i);
        inv |= snoop_inval_o === 1'b1;
        drop |= eu_grant_o === 1'b0;
      end
    join
    chk("snoop_inval_o", snp, inv);
    chk("eu_grant_o", snp, drop);
    chk("eu_hit_o", !snp, eu_hit_o);
    eu_req_i = 1'b0;
  endtask
  task automatic complete_run();
    if (miscompares == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // The sequence needs about a hundred and twenty cycles, under two thousand even if every
  // loop limit runs out, so five thousand cycles means the run has hung.
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end
  // Main sequence.
  initial begin
    repeat (10) @(negedge clk_i);
    chk("bus_start_n_o", 1, bus_start_n_o);
    rst_b_i = 1'b1;
    // Lower bound on answer time is the qualified period times the wait count.
    rd(32'h0000_1234, 2);
    wait_cfg_i = 4'hF;
    qdiv = 2;
    rd(32'h8000_ABC0, 30);
    wait_cfg_i = 4'h0;
    qdiv = 4;
    rd(32'h0000_5678, 0);
    qdiv = 1;
    sn(32'h0000_0A50, 1'b1);
    sn(32'h0000_0B60, 1'b0);
    // Freeze the bus, then hold a request against it; it must wait for the thaw.
    qdiv = 0;
    repeat (6) @(negedge clk_i);
    fork
      rd(32'h0000_9ABC, 0);
      begin
        repeat (6) @(negedge clk_i);
        chk("req_ready_o", 0, req_ready_o);
        chk("bus_active_o", 0, bus_active_o);
        chk("bus_start_n_o", 1, bus_start_n_o);
        qdiv = 1;
      end
    join
    complete_run();
  end
endmodule
`default_nettype wire
